/* dmshp_pkg.sv */
// shared constants and types of the dual mode serial host port
package dmshp_pkg;

  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam int REG_AW = 7;
  localparam int REG_DW = 8;
  localparam logic [6:0] LOOP_MODE_ADDR = 7'h1F;
  localparam logic [6:0] IRQ_SVC_ADDR = 7'h7E;
  localparam logic [6:0] IRQ_EN_ADDR = 7'h7F;
  localparam logic [7:0] LOOP_MODE_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] IRQ_SVC_RST = 8'h00;
  localparam logic MODE_I2C_RST = 1'b1;

  // ----------------------------------------------------------------
  // framing counts
  // ----------------------------------------------------------------
  localparam int SPI_RW_BIT = 7;
  localparam logic [4:0] SPI_CMD_END = 5'h07;
  localparam logic [4:0] SPI_DATA_END = 5'h0F;
  localparam logic [4:0] SPI_SO_LOAD = 5'h10;
  localparam logic [4:0] SPI_CNT_MAX = 5'h18;
  localparam logic [3:0] I2C_LAST_BIT = 4'h7;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  localparam logic [3:0] I2C_ADDR_HI_DEF = 4'h6;

  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_REG, I_WR, I_RD} dmshp_i2c_st_t;

endpackage

/* dmshp_regmem.sv */
// register storage of the host port with registered read data
`timescale 1ns/1ps
module dmshp_regmem
  import dmshp_pkg::*;
#(
  parameter int AW = REG_AW,
  parameter int DW = REG_DW
)
(
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial
  begin
    if (AW < 1 || AW > 12 || DW < 1)
      $error("dmshp_regmem: unsupported size");
  end

  // storage has no reset; reads before the first write return undefined data
  always_ff @(posedge mclk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end

endmodule

/* dmshp_top.sv */
// dual mode serial host port: spi or i2c slave into the control registers
`timescale 1ns/1ps
module dmshp_top
  import dmshp_pkg::*;
#(
  parameter logic [3:0] I2C_ADDR_HI = I2C_ADDR_HI_DEF,
  parameter int STATUS_W = 8
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic i2c_en,
  input wire logic sck_scl_i,
  output logic sck_scl_o,
  output logic sck_scl_oe,
  input wire logic si_sda_i,
  output logic si_sda_o,
  output logic si_sda_oe,
  output logic so,
  input wire logic select_or_addr_bit0,
  input wire logic addr_pick_1,
  input wire logic addr_pick_2,
  input wire logic [STATUS_W-1:0] status_in,
  output logic int_o,
  output logic int_oe,
  output logic [7:0] loop_mode
);

  initial
  begin
    if (STATUS_W < 1 || STATUS_W > REG_DW)
      $error("dmshp_top: STATUS_W must be 1 to 8");
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // mode select and pin synchronisers
  // ----------------------------------------------------------------
  logic mode_s1;
  logic i2c_mode;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      mode_s1 <= MODE_I2C_RST;
      i2c_mode <= MODE_I2C_RST;
    end
    else
    begin
      mode_s1 <= i2c_en;
      i2c_mode <= mode_s1;
    end
  end

  always_ff @(posedge mclk)
  begin
    {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, sck_scl_i};
    {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, si_sda_i};
  end

  // ----------------------------------------------------------------
  // spi link logic on the spi clock
  // ----------------------------------------------------------------
  logic [4:0] spi_cnt;
  logic [7:0] spi_sh;
  logic [7:0] spi_cmd;
  logic [7:0] spi_wdata;
  logic spi_wr_full;
  logic spi_rd_req;
  logic [7:0] so_sh;
  logic [7:0] spi_rd_hold;
  wire [7:0] spi_byte = {spi_sh[6:0], si_sda_i};

  // chip select high clears the bit count, so each frame starts afresh
  always_ff @(posedge sck_scl_i or posedge select_or_addr_bit0)
  begin
    if (select_or_addr_bit0)
      spi_cnt <= 5'h00;
    else if (spi_cnt != SPI_CNT_MAX)
      spi_cnt <= spi_cnt + 5'h01;
  end

  // request flags outlive the frame so the mclk side never misses them
  always_ff @(posedge sck_scl_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      spi_wr_full <= 1'b0;
      spi_rd_req <= 1'b0;
    end
    else if (spi_cnt == 5'h00)
    begin
      spi_wr_full <= 1'b0;
      spi_rd_req <= 1'b0;
    end
    else if (spi_cnt == SPI_CMD_END)
      spi_rd_req <= spi_byte[SPI_RW_BIT];
    else if (spi_cnt == SPI_DATA_END)
      spi_wr_full <= ~spi_cmd[SPI_RW_BIT];
  end

  always_ff @(posedge sck_scl_i)
  begin
    spi_sh <= spi_byte;
    if (spi_cnt == SPI_CMD_END)
      spi_cmd <= spi_byte;
    if (spi_cnt == SPI_DATA_END)
      spi_wdata <= spi_byte;
  end

  // read data is fetched during the dummy byte and shifted out on the third
  always_ff @(negedge sck_scl_i or negedge rst_b)
  begin
    if (!rst_b)
      so_sh <= 8'h00;
    else if (spi_cnt == SPI_SO_LOAD)
      so_sh <= spi_rd_hold;
    else
      so_sh <= {so_sh[6:0], 1'b0};
  end

  assign so = i2c_mode ? 1'b0 : so_sh[7];

  // ----------------------------------------------------------------
  // spi requests into the mclk domain
  // ----------------------------------------------------------------
  logic wf_s1, wf_s2, wf_s3;
  logic rq_s1, rq_s2, rq_s3;
  logic spi_fetch_d;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      {wf_s3, wf_s2, wf_s1} <= 3'h0;
      {rq_s3, rq_s2, rq_s1} <= 3'h0;
    end
    else
    begin
      {wf_s3, wf_s2, wf_s1} <= {wf_s2, wf_s1, spi_wr_full};
      {rq_s3, rq_s2, rq_s1} <= {rq_s2, rq_s1, spi_rd_req};
    end
  end

  wire spi_commit = wf_s2 & ~wf_s3 & ~i2c_mode;
  wire spi_fetch = rq_s2 & ~rq_s3 & ~i2c_mode;

  // ----------------------------------------------------------------
  // i2c slave on oversampled scl and sda
  // ----------------------------------------------------------------
  dmshp_i2c_st_t i2c_st;
  logic [3:0] i2c_bit;
  logic [7:0] i2c_sh;
  logic [7:0] i2c_osh;
  logic [6:0] i2c_ptr;
  logic sda_low;
  logic i2c_wr;
  logic [6:0] i2c_wa;
  logic [7:0] i2c_wd;
  logic [7:0] rd_val;

  logic [2:0] asel_s1;
  logic [2:0] asel_s2;

  // address straps are pins: two flops before the compare reads them
  always_ff @(posedge mclk)
  begin
    asel_s1 <= {addr_pick_2, addr_pick_1, select_or_addr_bit0};
    asel_s2 <= asel_s1;
  end

  wire [6:0] own_addr = {I2C_ADDR_HI, asel_s2};
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire i2c_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire i2c_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire addr_hit = (i2c_sh[7:1] == own_addr);
  wire byte_end = scl_fall && (i2c_bit == I2C_LAST_BIT) && (i2c_st != I_IDLE);
  wire ack_end = scl_fall && (i2c_bit == I2C_ACK_BIT) && (i2c_st != I_IDLE);

  always_ff @(posedge mclk)
  begin
    i2c_wr <= 1'b0;
    if (!rst_b || !i2c_mode)
    begin
      i2c_st <= I_IDLE;
      i2c_bit <= 4'h0;
      sda_low <= 1'b0;
      if (!rst_b)
        i2c_ptr <= 7'h00;
    end
    else if (i2c_start)
    begin
      i2c_st <= I_ADDR;
      // the scl fall that follows start wraps this to bit 0
      i2c_bit <= 4'hF;
      sda_low <= 1'b0;
    end
    else if (i2c_stop)
    begin
      i2c_st <= I_IDLE;
      sda_low <= 1'b0;
    end
    else if (scl_rise && i2c_bit != I2C_ACK_BIT)
      i2c_sh <= {i2c_sh[6:0], sda_s2};
    else if (scl_rise && i2c_st == I_RD && sda_s2)
      i2c_st <= I_IDLE;
    else if (byte_end)
    begin
      i2c_bit <= I2C_ACK_BIT;
      sda_low <= (i2c_st != I_RD);
      unique case (i2c_st)
        I_ADDR:
        begin
          if (!addr_hit)
          begin
            i2c_st <= I_IDLE;
            sda_low <= 1'b0;
          end
        end
        I_REG: i2c_ptr <= i2c_sh[6:0];
        I_WR:
        begin
          i2c_wr <= 1'b1;
          i2c_wa <= i2c_ptr;
          i2c_wd <= i2c_sh;
          i2c_ptr <= i2c_ptr + 7'h01;
        end
        I_RD: i2c_ptr <= i2c_ptr + 7'h01;
        I_IDLE: i2c_st <= I_IDLE;
      endcase
    end
    else if (ack_end)
    begin
      i2c_bit <= 4'h0;
      sda_low <= 1'b0;
      if ((i2c_st == I_ADDR && i2c_sh[0]) || i2c_st == I_RD)
      begin
        i2c_st <= I_RD;
        i2c_osh <= rd_val;
        sda_low <= ~rd_val[7];
      end
      else if (i2c_st == I_ADDR)
        i2c_st <= I_REG;
      else
        i2c_st <= I_WR;
    end
    else if (scl_fall && i2c_st != I_IDLE)
    begin
      i2c_bit <= i2c_bit + 4'h1;
      if (i2c_st == I_RD)
      begin
        i2c_osh <= {i2c_osh[6:0], 1'b0};
        sda_low <= ~i2c_osh[6];
      end
    end
  end

  // open drain lines: only ever pulled low; scl is never stretched
  assign si_sda_o = 1'b0;
  assign si_sda_oe = sda_low & i2c_mode;
  assign sck_scl_o = 1'b0;
  assign sck_scl_oe = 1'b0;

  // ----------------------------------------------------------------
  // register access, interrupt service and loop mode
  // ----------------------------------------------------------------
  wire wr_en = i2c_mode ? i2c_wr : spi_commit;
  wire [6:0] wr_addr = i2c_mode ? i2c_wa : spi_cmd[6:0];
  wire [7:0] wr_data = i2c_mode ? i2c_wd : spi_wdata;
  wire [6:0] rd_addr = i2c_mode ? i2c_ptr : spi_cmd[6:0];
  logic [6:0] rd_addr_q;
  logic [7:0] mem_q;
  logic [7:0] irq_service_regs;
  logic [7:0] irq_en;
  logic [STATUS_W-1:0] status_q;
  wire [7:0] status_chg = 8'(status_in ^ status_q);
  wire [7:0] svc_clr = (wr_en && wr_addr == IRQ_SVC_ADDR) ? wr_data : 8'h00;

  assign rd_val = (rd_addr_q == IRQ_SVC_ADDR) ? irq_service_regs :
                  (rd_addr_q == IRQ_EN_ADDR) ? irq_en : mem_q;

  dmshp_regmem #(.AW(REG_AW), .DW(REG_DW)) u_mem (
    .mclk(mclk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(mem_q)
  );

  always_ff @(posedge mclk)
  begin
    rd_addr_q <= rd_addr;
    spi_fetch_d <= spi_fetch;
    if (spi_fetch_d)
      spi_rd_hold <= rd_val;
  end

  // a status change in the same cycle as a clear keeps its flag set
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      irq_service_regs <= IRQ_SVC_RST;
      irq_en <= IRQ_EN_RST;
      loop_mode <= LOOP_MODE_RST;
      status_q <= status_in;
      int_oe <= 1'b0;
    end
    else
    begin
      status_q <= status_in;
      irq_service_regs <= (irq_service_regs & ~svc_clr) | status_chg;
      int_oe <= |(irq_service_regs & irq_en);
      if (wr_en && wr_addr == IRQ_EN_ADDR)
        irq_en <= wr_data;
      if (wr_en && wr_addr == LOOP_MODE_ADDR)
        loop_mode <= wr_data;
    end
  end

  assign int_o = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_MODE_FROM_RESET: assert property ($rose(rst_b) |-> i2c_mode)
    else $error("mode is not i2c after reset");
  AST_MODE_FOLLOWS_PIN: assert property ($rose(mode_s1) |=> i2c_mode)
    else $error("mode did not follow select input");
  AST_SCL_NOT_DRIVEN: assert property (!sck_scl_oe && !sck_scl_o)
    else $error("scl line driven");
  AST_SDA_QUIET_SPI: assert property (!i2c_mode |-> !si_sda_oe && !si_sda_o)
    else $error("sda driven outside i2c mode");
  AST_SO_IDLE_I2C: assert property (i2c_mode |-> so == 1'b0)
    else $error("serial output active in i2c mode");
  AST_SPI_IDLE_CS_HIGH: assert property (!i2c_mode && select_or_addr_bit0 |-> spi_cnt == 5'h00)
    else $error("spi bit count runs while chip select is high");
  AST_ADDR_MISS_IDLE: assert property (byte_end && i2c_st == I_ADDR && !addr_hit
    |=> i2c_st == I_IDLE && !sda_low)
    else $error("foreign address acknowledged");
  AST_STATUS_RAISES_INT: assert property (|(status_chg & irq_en) && !(wr_en
    && wr_addr == IRQ_EN_ADDR) |=> ##1 int_oe)
    else $error("status change did not raise interrupt");
  AST_INT_OPEN_DRAIN: assert property (int_o == 1'b0 && (int_oe == $past(|(irq_service_regs
    & irq_en))))
    else $error("interrupt pin not open drain");
  AST_LOOP_WRITE: assert property (wr_en && wr_addr == LOOP_MODE_ADDR
    |=> loop_mode == $past(wr_data))
    else $error("loop mode write lost");

endmodule

/* dmshp_host.sv */
// host model: spi or i2c master on the shared serial pins
`timescale 1ns/1ps
module dmshp_host
(
  input wire logic sda_pin,
  input wire logic so,
  output logic sck,
  output logic sd,
  output logic cs_b
);
  logic lclk = 1'b0;
  logic run = 1'b0;
  logic scl = 1'b1;

  // --------------------------------------------------------------
  // link clock: free running, reaches the pin only inside frames
  // --------------------------------------------------------------
  initial
  begin
    sd = 1'b1;
    cs_b = 1'b1;
    #3.7;
    forever #15 lclk = ~lclk;
  end
  assign sck = run ? lclk : scl;

  // data changes on the falling edge so the device samples it settled
  task automatic spi(input logic [23:0] w, input int n, output logic [7:0] r);
    r = 8'h00;
    @(negedge lclk);
    scl = 1'b0;
    cs_b = 1'b0;
    sd = w[23];
    @(negedge lclk);
    run = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge lclk);
      if (i >= 16)
        r = {r[6:0], so};
      @(negedge lclk);
      w = w << 1;
      sd = w[23];
    end
    run = 1'b0;
    @(negedge lclk);
    cs_b = 1'b1;
    sd = ~sd;
    repeat (2) @(negedge lclk);
  endtask

  // two link periods per phase keeps scl high and low above 50 ns
  task automatic ph();
    repeat (2) @(negedge lclk);
  endtask

  task automatic bit_out(input logic b, output logic s);
    sd = b;
    ph();
    scl = 1'b1;
    ph();
    s = sda_pin;
    scl = 1'b0;
    ph();
  endtask

  task automatic i2c_wr(input logic [6:0] a, input logic [7:0] rg, input logic [7:0] d,
    output logic ok);
    logic [26:0] f;
    logic s;
    f = {a, 1'b0, 1'b1, rg, 1'b1, d, 1'b1};
    ok = 1'b1;
    sd = 1'b1;
    scl = 1'b1;
    ph();
    sd = 1'b0;
    ph();
    scl = 1'b0;
    ph();
    for (int i = 0; i < 27; i++)
    begin
      bit_out(f[26 - i], s);
      if (i % 9 == 8)
        ok = ok & ~s;
    end
    sd = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sd = 1'b1;
    ph();
  endtask
endmodule

/* dmshp_test.sv */
// self-checking bench of the dual mode serial host port
`timescale 1ns/1ps
`define CHK(n, e, a) \
  num_checks++; \
  if ((a) !== (e)) \
  begin \
    error_cnt++; \
    $display("ERROR %s expected %h seen %h", n, e, a); \
  end
module dmshp_test
  import dmshp_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b, i2c_en, a0, a1, a2, ok;
  logic sck, sd, cs_b, sda, scl, so, oe_sda, oe_scl, o_scl, o_sda, int_o, int_oe;
  logic [7:0] status_in, loop_mode, obs, rd, lm, x, act;
  logic [6:0] adr;
  logic [31:0] rn = 32'h0521;
  int error_cnt = 0;
  int num_checks = 0;
  typedef struct {string n; int k; logic [7:0] e;} dmshp_note_t;
  dmshp_note_t q[$];
  dmshp_note_t t;
  event look;

  // pins are pulled up; whoever enables its driver pulls low
  assign sda = oe_sda ? 1'b0 : sd;
  assign scl = oe_scl ? 1'b0 : sck;

  dmshp_top dut (.mclk(mclk), .rst_b(rst_b), .i2c_en(i2c_en), .sck_scl_i(scl),
    .sck_scl_o(o_scl), .sck_scl_oe(oe_scl), .si_sda_i(sda), .si_sda_o(o_sda),
    .si_sda_oe(oe_sda), .so(so), .select_or_addr_bit0(i2c_en ? a0 : cs_b),
    .addr_pick_1(a1), .addr_pick_2(a2), .status_in(status_in), .int_o(int_o),
    .int_oe(int_oe), .loop_mode(loop_mode));
  dmshp_host host (.sda_pin(sda), .so(so), .sck(sck), .sd(sd), .cs_b(cs_b));

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string n, input int k, input logic [7:0] e);
    q.push_back('{n, k, e});
    ->look;
  endtask

  task automatic iw(input logic [6:0] rg, input logic [7:0] d);
    host.i2c_wr(adr, {1'b0, rg}, d, ok);
    tick(6);
  endtask

  task automatic sw(input logic [6:0] rg, input logic [7:0] d);
    host.spi({1'b0, rg, d, 8'h00}, 16, rd);
    tick(6);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // monitor: each note is compared with the output that it names
  // --------------------------------------------------------------
  always @(look)
    while (q.size() > 0)
    begin
      t = q.pop_front();
      case (t.k)
        0: act = loop_mode;
        1: act = {7'h00, int_oe};
        2: act = obs;
        default: act = {2'h0, so, oe_sda, oe_scl, o_scl, o_sda, int_o};
      endcase
      `CHK(t.n, t.e, act)
    end

  initial
  begin
    #500000;
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    rst_b = 1'b0;
    i2c_en = 1'b1;
    {a2, a1, a0} = 3'h0;
    status_in = 8'h00;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    tick(6);
    chk("idle pins", 3, 8'h00);
    chk("loop reset", 0, LOOP_MODE_RST);
    chk("int reset", 1, 8'h00);
    $display("reset test done");
    rn = lfsr(rn);
    lm = rn[15:8];
    @(posedge mclk) {a2, a1, a0} <= rn[2:0];
    tick(4);
    adr = {I2C_ADDR_HI_DEF, rn[2:0]};
    iw(LOOP_MODE_ADDR, lm);
    obs = {7'h00, ok};
    chk("i2c ack", 2, 8'h01);
    chk("i2c write", 0, lm);
    chk("i2c idle pins", 3, 8'h00);
    for (int b = 0; b < 3; b++)
    begin
      host.i2c_wr(adr ^ (7'h01 << b), {1'b0, LOOP_MODE_ADDR}, ~lm, ok);
      tick(6);
      obs = {7'h00, ok};
      chk("foreign ack", 2, 8'h00);
      chk("foreign write", 0, lm);
    end
    $display("i2c test done");
    iw(IRQ_EN_ADDR, 8'h00);
    rn = lfsr(rn);
    @(posedge mclk) status_in <= rn[7:0] | 8'h01;
    tick(4);
    chk("int masked", 1, 8'h00);
    iw(IRQ_EN_ADDR, 8'hFF);
    chk("int raised", 1, 8'h01);
    iw(IRQ_SVC_ADDR, 8'hFF);
    chk("int cleared", 1, 8'h00);
    $display("interrupt test done");
    // mode only changes while no transfer is in flight
    @(posedge mclk) i2c_en <= 1'b0;
    tick(6);
    rn = lfsr(rn);
    lm = rn[7:0];
    sw(LOOP_MODE_ADDR, lm);
    chk("spi write", 0, lm);
    host.spi({1'b1, LOOP_MODE_ADDR, 16'h0000}, 24, rd);
    obs = rd;
    chk("spi read", 2, lm);
    host.spi({1'b0, LOOP_MODE_ADDR, ~lm, 8'h00}, 12, rd);
    tick(6);
    chk("spi cut frame", 0, lm);
    host.i2c_wr(adr, {1'b0, LOOP_MODE_ADDR}, ~lm, ok);
    tick(6);
    obs = {7'h00, ok};
    chk("i2c in spi mode", 2, 8'h00);
    chk("i2c in spi write", 0, lm);
    x = rn[15:8] | 8'h01;
    @(posedge mclk) status_in <= status_in ^ x;
    tick(4);
    chk("spi int raised", 1, 8'h01);
    host.spi({1'b1, IRQ_SVC_ADDR, 16'h0000}, 24, rd);
    obs = rd;
    chk("service flags", 2, x);
    sw(IRQ_SVC_ADDR, x);
    chk("spi int cleared", 1, 8'h00);
    $display("spi test done");
    @(posedge mclk) i2c_en <= 1'b1;
    tick(6);
    sw(LOOP_MODE_ADDR, ~lm);
    chk("spi in i2c mode", 0, lm);
    chk("i2c pins again", 3, 8'h00);
    $display("mode return test done");
    #1;
    wrap_up();
  end
endmodule
